// ==== pkg/stpb_consts.svh ====
// constants of the sensor trim parameter bank: word indices,
// field positions, reset values and bus layout.
// assumes a 32-bit wishbone slave, one 24-bit word per aligned word.
`ifndef STPB_CONSTS_SVH
`define STPB_CONSTS_SVH

// ****************************************
// word indices; byte address is four times
// ****************************************
`define STPB_IDX_TC2      6'h08
`define STPB_IDX_TC1      6'h09
`define STPB_IDX_GAIN     6'h0a
`define STPB_IDX_POL      6'h1b
`define STPB_IDX_QVO      6'h1d
`define STPB_IDX_NOTES_C  6'h1f
`define STPB_IDX_STATUS   6'h20

// ****************************************
// field positions
// ****************************************
`define STPB_POL_BIT      22
`define STPB_QVO_LSB      0
`define STPB_QVO_MSB      11
`define STPB_GAIN_LSB     0
`define STPB_GAIN_MSB     11
`define STPB_NOTES_LSB    12
`define STPB_NOTES_MSB    23
`define STPB_OFS1_LSB     0
`define STPB_OFS1_MSB     7
`define STPB_TC1C_LSB     8
`define STPB_TC1C_MSB     15
`define STPB_TC1H_LSB     16
`define STPB_TC1H_MSB     23
`define STPB_TC2C_LSB     6
`define STPB_TC2C_MSB     14
`define STPB_TC2H_LSB     15
`define STPB_TC2H_MSB     23

// ****************************************
// reset values, word count and data width
// ****************************************
`define STPB_WORD_RST     24'h000000
`define STPB_FACT_TC1     8'h00
`define STPB_FACT_TC2     9'h000
`define STPB_WORDS        6
`define STPB_DAT_W        32

`endif

// ==== pkg/stpb_pkg.sv ====
// types of the sensor trim parameter bank.
// assumes stpb_consts.svh is included by the design files.
package stpb_pkg;

  typedef logic [23:0] stpb_word_t;
  typedef logic [2:0]  stpb_slot_t;

  // read path idle -> fetch -> answer -> idle; writes go idle -> answer
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FETCH  = 2'b01,
    ST_ANSWER = 2'b11
  } stpb_bus_state_t;

endpackage

// ==== rtl/stpb_word_store.sv ====
// six 24-bit parameter words with byte-lane writes and a
// registered read port; all words are also presented flat.
// assumes one write per cycle and a slot index below six.
`timescale 1ns/1ns
`default_nettype none
`include "stpb_consts.svh"

module stpb_word_store (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_ce,
  input  wire logic                  i_we,
  input  wire logic [2:0]            i_wsel,
  input  wire stpb_pkg::stpb_slot_t  i_addr,
  input  wire stpb_pkg::stpb_word_t  i_wdata,
  output stpb_pkg::stpb_word_t       o_rdata,
  output logic [6*24-1:0]            o_words
);

  stpb_pkg::stpb_word_t mem_reg [`STPB_WORDS];

  // ****************************************
  // byte-lane merge
  // ****************************************
  function automatic stpb_pkg::stpb_word_t merge(
    input stpb_pkg::stpb_word_t old_w,
    input stpb_pkg::stpb_word_t new_w,
    input logic [2:0]           sel
  );
    stpb_pkg::stpb_word_t res;
    res = old_w;
    for (int b = 0; b < 3; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < `STPB_WORDS; i++) begin
        mem_reg[i] <= `STPB_WORD_RST;
      end
    end else if (i_ce && i_we) begin
      // untouched lanes keep their fields
      mem_reg[i_addr] <= merge(mem_reg[i_addr], i_wdata, i_wsel);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= `STPB_WORD_RST;
    end else if (i_ce) begin
      o_rdata <= mem_reg[i_addr];
    end
  end

  always_comb begin
    for (int i = 0; i < `STPB_WORDS; i++) begin
      o_words[i*24 +: 24] = mem_reg[i];
    end
  end

endmodule
`default_nettype wire

// ==== rtl/stpb_top.sv ====
// sensor trim parameter bank: wishbone classic slave over six
// parameter words, field decode, polarity, baseline and the
// hot/cold tempco selection.
// assumes a single synchronous clock and inputs synchronous to it;
// i_diff is left channel minus right channel, signed.
`timescale 1ns/1ns
`default_nettype none
`include "stpb_consts.svh"

module stpb_top (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire logic         i_wb_cyc,
  input  wire logic         i_wb_stb,
  input  wire logic         i_wb_we,
  input  wire logic [7:0]   i_wb_adr,
  input  wire logic [3:0]   i_wb_sel,
  input  wire logic [31:0]  i_wb_dat,
  output logic [31:0]       o_wb_dat,
  output logic              o_wb_ack,
  input  wire logic         i_temp_hot,
  input  wire logic         i_temp_cold,
  input  wire logic [11:0]  i_diff,
  output logic [12:0]       o_out_level,
  output logic [11:0]       o_gain_multiplier,
  output logic [7:0]        o_offset_tempco,
  output logic [7:0]        o_sens_tc1,
  output logic [8:0]        o_sens_tc2,
  output logic              o_use_factory_tc
);

  // ****************************************
  // address decode
  // ****************************************
  localparam stpb_pkg::stpb_slot_t SLOT_STATUS = 3'h6;
  localparam stpb_pkg::stpb_slot_t SLOT_NONE   = 3'h7;

  function automatic stpb_pkg::stpb_slot_t slot_of(
    input logic [7:0] adr
  );
    stpb_pkg::stpb_slot_t s;
    s = SLOT_NONE;
    if (adr[1:0] == 2'h0) begin
      unique case (adr[7:2])
        `STPB_IDX_TC2:     s = 3'h0;
        `STPB_IDX_TC1:     s = 3'h1;
        `STPB_IDX_GAIN:    s = 3'h2;
        `STPB_IDX_POL:     s = 3'h3;
        `STPB_IDX_QVO:     s = 3'h4;
        `STPB_IDX_NOTES_C: s = 3'h5;
        `STPB_IDX_STATUS:  s = SLOT_STATUS;
        default:           s = SLOT_NONE;
      endcase
    end
    return s;
  endfunction

  function automatic logic is_word(
    input stpb_pkg::stpb_slot_t s
  );
    return s < SLOT_STATUS;
  endfunction

  // ****************************************
  // bus handshake
  // ****************************************
  stpb_pkg::stpb_bus_state_t state_reg;
  stpb_pkg::stpb_slot_t      slot;
  stpb_pkg::stpb_slot_t      slot_reg;
  stpb_pkg::stpb_word_t      rdata;
  logic [6*24-1:0]           words;
  logic                      req;
  logic                      wr_word;
  logic [3:0]                prog_reg;

  assign slot    = slot_of(i_wb_adr);
  assign req     = i_wb_cyc && i_wb_stb && (state_reg == stpb_pkg::ST_IDLE);
  assign wr_word = req && i_wb_we && is_word(slot);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= stpb_pkg::ST_IDLE;
    end else if (i_ce) begin
      unique case (state_reg)
        stpb_pkg::ST_IDLE: begin
          if (req && i_wb_we) begin
            state_reg <= stpb_pkg::ST_ANSWER;
          end else if (req) begin
            state_reg <= stpb_pkg::ST_FETCH;
          end
        end
        stpb_pkg::ST_FETCH: begin
          state_reg <= stpb_pkg::ST_ANSWER;
        end
        stpb_pkg::ST_ANSWER: begin
          state_reg <= stpb_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= stpb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      slot_reg <= SLOT_NONE;
    end else if (i_ce && req) begin
      slot_reg <= slot;
    end
  end

  // ack stands for one cycle; writes answer a cycle sooner
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
    end else if (i_ce) begin
      o_wb_ack <= (req && i_wb_we) ||
                  (state_reg == stpb_pkg::ST_FETCH);
    end
  end

  // unmapped and misaligned reads return zero, high byte reads zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_dat <= 32'h0;
    end else if (i_ce && state_reg == stpb_pkg::ST_FETCH) begin
      if (is_word(slot_reg)) begin
        o_wb_dat <= {8'h00, rdata};
      end else if (slot_reg == SLOT_STATUS) begin
        o_wb_dat <= {24'h0, i_temp_hot, i_temp_cold,
                     o_use_factory_tc, 1'b0, prog_reg};
      end else begin
        o_wb_dat <= 32'h0;
      end
    end
  end

  stpb_word_store u_store (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_we    (wr_word),
    .i_wsel  (i_wb_sel[2:0]),
    .i_addr  (is_word(slot) ? slot : 3'h0),
    .i_wdata (i_wb_dat[23:0]),
    .o_rdata (rdata),
    .o_words (words)
  );

  // ****************************************
  // field views of the stored words
  // ****************************************
  stpb_pkg::stpb_word_t w_tc2;
  stpb_pkg::stpb_word_t w_tc1;
  stpb_pkg::stpb_word_t w_gain;
  stpb_pkg::stpb_word_t w_pol;
  stpb_pkg::stpb_word_t w_qvo;
  logic                 polarity_flip;
  logic signed [11:0]   quiescent_level_code;
  logic [8:0]           second_order_sens_cold;
  logic [8:0]           second_order_sens_hot;
  logic [7:0]           first_order_sens_cold;
  logic [7:0]           first_order_sens_hot;

  assign w_tc2  = words[0*24 +: 24];
  assign w_tc1  = words[1*24 +: 24];
  assign w_gain = words[2*24 +: 24];
  assign w_pol  = words[3*24 +: 24];
  assign w_qvo  = words[4*24 +: 24];
  // scratch bits of 0x0a, 0x1d and all of 0x1f are never read here
  // beyond the bus read path

  assign polarity_flip = w_pol[`STPB_POL_BIT];
  assign quiescent_level_code =
    w_qvo[`STPB_QVO_MSB:`STPB_QVO_LSB];
  assign second_order_sens_cold =
    w_tc2[`STPB_TC2C_MSB:`STPB_TC2C_LSB];
  assign second_order_sens_hot =
    w_tc2[`STPB_TC2H_MSB:`STPB_TC2H_LSB];
  assign first_order_sens_cold =
    w_tc1[`STPB_TC1C_MSB:`STPB_TC1C_LSB];
  assign first_order_sens_hot =
    w_tc1[`STPB_TC1H_MSB:`STPB_TC1H_LSB];

  // ****************************************
  // programmed flags of the sensitivity tempcos
  // ****************************************
  // bit0 tc2 cold, bit1 tc2 hot, bit2 tc1 cold, bit3 tc1 hot;
  // only reset clears them, so no write can be lost
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prog_reg <= 4'h0;
    end else if (i_ce && wr_word && slot == 3'h0) begin
      prog_reg[0] <= prog_reg[0] | i_wb_sel[0] | i_wb_sel[1];
      prog_reg[1] <= prog_reg[1] | i_wb_sel[1] | i_wb_sel[2];
    end else if (i_ce && wr_word && slot == 3'h1) begin
      prog_reg[2] <= prog_reg[2] | i_wb_sel[1];
      prog_reg[3] <= prog_reg[3] | i_wb_sel[2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_use_factory_tc <= 1'b1;
    end else if (i_ce) begin
      o_use_factory_tc <= (prog_reg == 4'h0);
    end
  end

  // ****************************************
  // tempco selection around 25 c
  // ****************************************
  // at exactly 25 c the second order term is zero and tc1 takes the cold value once any tempco flag is set, else the factory value
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sens_tc2 <= `STPB_FACT_TC2;
    end else if (i_ce) begin
      if (prog_reg == 4'h0) begin
        o_sens_tc2 <= `STPB_FACT_TC2;
      end else if (i_temp_hot) begin
        o_sens_tc2 <= second_order_sens_hot;
      end else if (i_temp_cold) begin
        o_sens_tc2 <= second_order_sens_cold;
      end else begin
        o_sens_tc2 <= 9'h000;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sens_tc1 <= `STPB_FACT_TC1;
    end else if (i_ce) begin
      if (prog_reg == 4'h0) begin
        o_sens_tc1 <= `STPB_FACT_TC1;
      end else if (i_temp_hot) begin
        o_sens_tc1 <= first_order_sens_hot;
      end else begin
        o_sens_tc1 <= first_order_sens_cold;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_offset_tempco <= 8'h00;
    end else if (i_ce) begin
      o_offset_tempco <= w_tc1[`STPB_OFS1_MSB:`STPB_OFS1_LSB];
    end
  end

  // multiplier on the factory sensitivity; scaling is downstream
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_gain_multiplier <= 12'h000;
    end else if (i_ce) begin
      o_gain_multiplier <= w_gain[`STPB_GAIN_MSB:`STPB_GAIN_LSB];
    end
  end

  // ****************************************
  // polarity and baseline
  // ****************************************
  // 13 bits so that baseline plus a full-scale swing cannot wrap
  logic signed [12:0] diff_ext;
  logic signed [12:0] diff_pol;

  assign diff_ext = {i_diff[11], i_diff};
  assign diff_pol = polarity_flip ? -diff_ext : diff_ext;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_out_level <= 13'h0000;
    end else if (i_ce) begin
      o_out_level <= {quiescent_level_code[11], quiescent_level_code}
                     + diff_pol;
    end
  end

  // scratch fields reach only the read path above

endmodule
`default_nettype wire

// ==== tb/stpb_top_sva.sv ====
// checker for the parameter bank: bus answer timing, read data
// hold, tempco selection and the factory flag. top ports only.
`timescale 1ns/1ns
`default_nettype none

module stpb_top_sva (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_ce,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_temp_hot,
  input wire logic        i_temp_cold,
  input wire logic [7:0]  o_sens_tc1,
  input wire logic [8:0]  o_sens_tc2,
  input wire logic        o_use_factory_tc
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // ****************
  // request starts
  // ****************
  // a fresh request follows a low strobe, so held ones are excluded
  sequence s_wr_req;
    i_ce && i_wb_cyc && i_wb_stb && i_wb_we && !$past(i_wb_stb);
  endsequence
  sequence s_rd_req;
    i_ce && i_wb_cyc && i_wb_stb && !i_wb_we && !$past(i_wb_stb);
  endsequence

  a_write_ack: assert property (s_wr_req |=> o_wb_ack)
    else $error("write not answered one cycle after take");
  a_read_ack: assert property (
    s_rd_req ##1 i_ce |-> !o_wb_ack ##1 o_wb_ack)
    else $error("read not answered two cycles after take");
  a_ack_pulse: assert property (o_wb_ack && i_ce |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (
    $rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_upper_zero: assert property (
    o_wb_ack |-> o_wb_dat[31:24] == 8'h00)
    else $error("read data upper byte not zero");
  a_dat_hold: assert property (!o_wb_ack |-> $stable(o_wb_dat))
    else $error("read data moved outside answer");
  a_tc2_idle: assert property (
    !i_temp_hot && !i_temp_cold && i_ce |=> o_sens_tc2 == 9'h000)
    else $error("second order term at room temperature");
  a_factory_once: assert property (
    !o_use_factory_tc |=> !o_use_factory_tc)
    else $error("factory flag came back without reset");
  a_factory_zero: assert property (
    o_use_factory_tc |-> o_sens_tc1 == 8'h00 && o_sens_tc2 == 9'h000)
    else $error("tempco nonzero while factory default used");
endmodule

`default_nettype wire

// ==== tb/stpb_top_tb.sv ====
// self-checking bench for the parameter bank: classic bus access,
// lane merges, field decode, tempco selection, polarity, baseline.
// assumes the design header and package are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "stpb_consts.svh"
`define CHK(n, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("ERROR %s exp %h got %h", n, e, g); \
  end \
end

module stpb_top_tb;
  logic        i_clk, i_rst, i_ce, i_wb_cyc, i_wb_stb, i_wb_we;
  logic        i_temp_hot, i_temp_cold, o_wb_ack, o_use_factory_tc, p;
  logic [7:0]  i_wb_adr, o_offset_tempco, o_sens_tc1;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat;
  logic [11:0] i_diff, o_gain_multiplier, d;
  logic [12:0] o_out_level;
  logic [8:0]  o_sens_tc2;
  logic [23:0] w, w8, w9;
  logic [7:0]  adrs [6] = '{8'h20, 8'h24, 8'h28, 8'h6c, 8'h74, 8'h7c};
  int          err_total, checks, seed;

  stpb_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_temp_hot(i_temp_hot),
    .i_temp_cold(i_temp_cold), .i_diff(i_diff), .o_out_level(o_out_level),
    .o_gain_multiplier(o_gain_multiplier), .o_offset_tempco(o_offset_tempco),
    .o_sens_tc1(o_sens_tc1), .o_sens_tc2(o_sens_tc2),
    .o_use_factory_tc(o_use_factory_tc));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ****************
  // helpers
  // ****************
  function automatic logic [12:0] exp_lvl(logic [11:0] q, logic [11:0] x,
                                          logic pol);
    exp_lvl = {q[11], q} + (pol ? -{x[11], x} : {x[11], x});
  endfunction
  function automatic logic [8:0] exp_tc2(logic [23:0] v, logic h, logic c);
    exp_tc2 = h ? v[23:15] : (c ? v[14:6] : 9'h000);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // junk in the upper byte: the slave must ignore it
  task automatic wb(input logic wr, input logic [7:0] a, input logic [23:0] v,
                    input logic [3:0] s, output logic [31:0] q);
    int n;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= wr;
    i_wb_adr <= a;
    i_wb_sel <= s;
    i_wb_dat <= {8'h5a, v};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    q = o_wb_dat;
    if (n >= 20) begin
      err_total++;
      $display("ERROR bus ack exp 1 got 0");
    end
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] v,
                    input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, v, s, q);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 24'h0, 4'hf, q);
    `CHK(n, e, q)
  endtask

  initial begin
    tick(20000);
    err_total++;
    end_sim();
  end

  initial begin
    seed = 32'h9cde;
    err_total = 0;
    checks = 0;
    {i_rst, i_ce, i_wb_cyc, i_wb_stb, i_wb_we} = 5'b11000;
    {i_temp_hot, i_temp_cold, i_wb_adr, i_wb_sel} = '0;
    i_wb_dat = '0;
    i_diff = '0;
    tick(6);
    i_rst <= 1'b0;
    tick(2);
    `CHK("factory", 1'b1, o_use_factory_tc);
    for (int i = 0; i < 6; i++) rdchk("word", adrs[i], 32'h0);
    rdchk("status", 8'h80, 32'h20);
    $display("test reset done");
    // offset lane only, then cold lane: only the latter is a tempco
    wr(8'h24, 24'hc0807f, 4'b0001);
    tick(2);
    `CHK("offset", 8'h7f, o_offset_tempco);
    `CHK("factory", 1'b1, o_use_factory_tc);
    wr(8'h24, 24'h334455, 4'b0010);
    rdchk("merge", 8'h24, 32'h00447f);
    `CHK("factory", 1'b0, o_use_factory_tc);
    w9 = 24'($random(seed));
    w8 = 24'($random(seed));
    wr(8'h24, w9, 4'hf);
    wr(8'h20, w8, 4'hf);
    for (int k = 0; k < 3; k++) begin
      i_temp_hot <= (k == 0);
      i_temp_cold <= (k == 1);
      tick(3);
      `CHK("tc1", (k == 0) ? w9[23:16] : w9[15:8], o_sens_tc1);
      `CHK("tc2", exp_tc2(w8, k == 0, k == 1), o_sens_tc2);
    end
    $display("test tempco done");
    for (int i = 0; i < 4; i++) begin
      w = 24'($random(seed));
      wr(8'h28, w, 4'hf);
      tick(2);
      `CHK("gain", w[11:0], o_gain_multiplier);
      rdchk("gain word", 8'h28, {8'h00, w});
    end
    wr(8'h7c, ~w, 4'hf);
    rdchk("notes", 8'h7c, {8'h00, ~w});
    tick(2);
    `CHK("gain kept", w[11:0], o_gain_multiplier);
    `CHK("level kept", 13'h0000, o_out_level);
    wr(8'h40, w, 4'hf);
    rdchk("unmapped", 8'h40, 32'h0);
    wr(8'h80, 24'hffffff, 4'hf);
    rdchk("status", 8'h80, 32'h0f);
    $display("test fields done");
    // first pass takes the extreme codes of both operands
    for (int i = 0; i < 8; i++) begin
      w = 24'($random(seed));
      d = (i == 0) ? 12'h800 : 12'($random(seed));
      p = (i == 0) ? 1'b1 : w[22];
      if (i == 0) w[11:0] = 12'h7ff;
      wr(8'h74, w, 4'hf);
      wr(8'h6c, {~w[23], p, w[21:0]}, 4'hf);
      i_diff <= d;
      tick(4);
      `CHK("level", exp_lvl(w[11:0], d, p), o_out_level);
      rdchk("baseline word", 8'h74, {8'h00, w});
    end
    // enable low: a new input must not reach the level until it returns
    i_ce <= 1'b0;
    i_diff <= ~d;
    tick(3);
    `CHK("frozen", exp_lvl(w[11:0], d, p), o_out_level);
    i_ce <= 1'b1;
    tick(2);
    `CHK("thawed", exp_lvl(w[11:0], ~d, p), o_out_level);
    $display("test polarity done");
    end_sim();
  end
endmodule

bind stpb_top stpb_top_sva u_sva (.i_clk(i_clk), .i_rst(i_rst),
  .i_ce(i_ce), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_temp_hot(i_temp_hot), .i_temp_cold(i_temp_cold),
  .o_sens_tc1(o_sens_tc1), .o_sens_tc2(o_sens_tc2),
  .o_use_factory_tc(o_use_factory_tc));

`default_nettype wire
